// file: rtc_pkg.sv
// Package: register map, field layout and timing constants of the realtime clock
package rtc_pkg;
   // Clock rate and prescaler base
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TICK_1MHZ_HZ = 1_000_000;
   localparam int unsigned DIV_1MHZ = CLK_HZ / TICK_1MHZ_HZ;
   // Rate select codes (13 internal rates)
   localparam logic [3:0] RATE_1MHZ = 4'h0;
   localparam logic [3:0] RATE_100KHZ = 4'h1;
   localparam logic [3:0] RATE_10KHZ = 4'h2;
   localparam logic [3:0] RATE_1KHZ = 4'h3;
   localparam logic [3:0] RATE_100HZ = 4'h4;
   localparam logic [3:0] RATE_10HZ = 4'h5;
   localparam logic [3:0] RATE_1HZ = 4'h6;
   localparam logic [3:0] RATE_P1HZ = 4'h7;
   localparam logic [3:0] RATE_P01HZ = 4'h8;
   localparam logic [3:0] RATE_1MIN = 4'h9;
   localparam logic [3:0] RATE_10MIN = 4'hA;
   localparam logic [3:0] RATE_1HOUR = 4'hB;
   localparam logic [3:0] RATE_50HZ = 4'hC;
   localparam logic [3:0] SRC_LINE = 4'hD;
   localparam logic [3:0] SRC_TRIG = 4'hE;
   localparam logic [3:0] LAST_LEGACY_RATE = 4'h4;
   // Decade prescaler: 1MHz down to 0.01Hz is eight divide-by-ten stages
   localparam int unsigned DECADES = 8;
   localparam int unsigned DECADE_DIV = 10;
   localparam int unsigned DIV_1MIN = 6;    // 0.1Hz / 6 = one per minute
   localparam int unsigned DIV_10MIN = 10;
   localparam int unsigned DIV_1HOUR = 6;
   localparam int unsigned DIV_50HZ = 2;    // 100Hz / 2
   // Modes
   typedef enum logic [2:0] {
      MODE_SINGLE, MODE_REPEAT, MODE_EVT_TIME, MODE_EVT_INTERVAL, MODE_FREQ
   } mode_t;
   // Byte addresses on AXI4-Lite
   localparam logic [3:0] ADDR_CSR = 4'h0;
   localparam logic [3:0] ADDR_PRESET = 4'h4;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
   // Command/status fields
   localparam int unsigned CSR_GO = 0;
   localparam int unsigned CSR_MODE_LO = 1;    // bits 3:1
   localparam int unsigned CSR_RATE_LO = 4;    // bits 7:4
   localparam int unsigned CSR_RUN = 8;        // read only
   localparam int unsigned CSR_OVF = 9;        // read only copy
   localparam int unsigned CSR_TRIG2 = 10;     // read only copy
   localparam int unsigned CSR_EXT = 11;       // read only strap
   // Interrupt bits
   localparam int unsigned IRQ_OVF = 0;
   localparam int unsigned IRQ_TRIG2 = 1;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: rtc_rate_gen.sv
// Rate generator: one-cycle ticks for every internal count rate
`timescale 1ns/100ps
module rtc_rate_gen
   import rtc_pkg::*;
#(
   parameter int unsigned PRE_DIV = DIV_1MHZ
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // One-cycle ticks per rate code
   output logic [12:0] tick
);
   logic [6:0] pre_r;
   logic [DECADES:0] dec_tick;
   logic tick_1min;
   logic tick_10min;
   logic tick_1hour;
   logic tick_50hz;
   logic [2:0] c1m_r;
   logic [3:0] c10m_r;
   logic [2:0] c1h_r;
   logic c50_r;

   // Base divider to 1MHz
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_r <= 7'h00;
      end else if (pre_r == 7'(PRE_DIV - 1)) begin
         pre_r <= 7'h00;
      end else begin
         pre_r <= pre_r + 7'h01;
      end
   end
   assign dec_tick[0] = (pre_r == 7'(PRE_DIV - 1));

   // Decade chain, one counter per stage
   genvar g;
   generate
      for (g = 0; g < DECADES; g++) begin : g_dec
         logic [3:0] cnt_r;
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               cnt_r <= 4'h0;
            end else if (dec_tick[g]) begin
               cnt_r <= (cnt_r == 4'(DECADE_DIV - 1)) ? 4'h0 : cnt_r + 4'h1;
            end
         end
         assign dec_tick[g+1] = dec_tick[g] && (cnt_r == 4'(DECADE_DIV - 1));
      end
   endgenerate

   // Long periods derived from the slow decades, and 50Hz from the 100Hz decade
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         c1m_r <= 3'h0;
         c10m_r <= 4'h0;
         c1h_r <= 3'h0;
         c50_r <= 1'b0;
      end else begin
         if (dec_tick[7]) begin
            c1m_r <= tick_1min ? 3'h0 : c1m_r + 3'h1;
         end
         if (tick_1min) begin
            c10m_r <= tick_10min ? 4'h0 : c10m_r + 4'h1;
         end
         if (tick_10min) begin
            c1h_r <= tick_1hour ? 3'h0 : c1h_r + 3'h1;
         end
         if (dec_tick[4]) begin
            c50_r <= ~c50_r;
         end
      end
   end
   assign tick_1min = dec_tick[7] && (c1m_r == 3'(DIV_1MIN - 1));
   assign tick_10min = tick_1min && (c10m_r == 4'(DIV_10MIN - 1));
   assign tick_1hour = tick_10min && (c1h_r == 3'(DIV_1HOUR - 1));
   assign tick_50hz = dec_tick[4] && c50_r;

   // Codes 0..8 are the decades, then minute, ten minutes, hour, 50Hz
   assign tick = {tick_50hz, tick_1hour, tick_10min, tick_1min, dec_tick[8:0]};
endmodule

// file: rtc_timer.sv
// Programmable realtime clock: counter, modes, triggers and AXI4-Lite registers
`timescale 1ns/100ps
// How it works
// - A 16-bit counter steps once per tick of the selected source.
// - Twelve crystal rates from 1MHz down to one per hour, plus 50Hz.
// - Line-time clock events or trigger channel 1 may also step the counter.
// - Modes: single, repeated interval, event timing, event interval, frequency count.
// - Frequency counting with endless interval gives plain event counting.
// - Without extended strap only the five fast rates and no frequency mode.
// - Two interrupt causes: counter overflow and trigger channel 2 event.
// - Interrupts come at programmed intervals or on external trigger events.
// - Command/status and buffer/preset registers configure and read the counter.
// - Triggers serve as event, timebase and frequency inputs, and are echoed out.
// - Overflow and trigger 1 strobes drive an external converter start.
module rtc_timer
   import rtc_pkg::*;
#(
   parameter int unsigned PRE_DIV = DIV_1MHZ,
   parameter int unsigned CNT_W = 16
) (
   // AXI4-Lite clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address channel
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // Write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read address channel
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // Read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Board inputs
   input wire logic ext_enable,
   input wire logic line_clk_evt,
   input wire logic trig1_in,
   input wire logic trig2_in,
   // Board outputs
   output logic ovf_strobe,
   output logic trig1_strobe,
   output logic trig2_level,
   output logic irq
);
   // Rate ticks and counter state
   logic [12:0] tick;
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] preset_r;
   logic [CNT_W-1:0] capture_r;
   mode_t mode_r;
   logic [3:0] rate_r;
   logic run_r;
   logic ext_r;
   logic [1:0] stat_r;
   logic [1:0] mask_r;
   logic [CNT_W-1:0] buf_view;

   // Trigger edges and count source
   logic t1_d_r;
   logic t2_d_r;
   logic t1_rise;
   logic t2_rise;
   logic src_tick;
   logic wrap;
   logic ovf_evt;
   logic go_w;

   // Held write request
   logic [3:0] aw_addr_r;
   logic aw_have_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic w_have_r;
   logic do_write;
   logic [31:0] csr_view;

   rtc_rate_gen #(
      .PRE_DIV(PRE_DIV)
   ) u_rates (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick)
   );

   // Strap level, registered so rate gating sees a clean copy
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_r <= 1'b0;
      end else begin
         ext_r <= ext_enable;
      end
   end

   // Trigger edge detection, inputs synchronous to aclk
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t1_d_r <= 1'b0;
         t2_d_r <= 1'b0;
      end else begin
         t1_d_r <= trig1_in;
         t2_d_r <= trig2_in;
      end
   end
   assign t1_rise = trig1_in && !t1_d_r;
   assign t2_rise = trig2_in && !t2_d_r;

   // Count source mux; restricted codes give no tick at all
   always_comb begin
      src_tick = 1'b0;
      if (rate_r == SRC_LINE) begin
         src_tick = line_clk_evt;
      end else if (rate_r == SRC_TRIG) begin
         src_tick = t1_rise;
      end else if (rate_r <= LAST_LEGACY_RATE || (ext_r && rate_r <= RATE_50HZ)) begin
         src_tick = tick[rate_r];
      end
   end

   // Frequency mode counts trigger 1 edges, gated by the internal rate as window
   assign wrap = (count_r == {CNT_W{1'b1}});
   // Only single and repeat modes flag a wrap
   assign ovf_evt = run_r && wrap && src_tick &&
      (mode_r == MODE_SINGLE || mode_r == MODE_REPEAT);

   // Writes wait until the last response has been taken
   assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
   assign go_w = do_write && aw_addr_r == ADDR_CSR && w_strb_r[0] && w_data_r[CSR_GO];

   // Counter, run state and capture buffer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_r <= COUNT_RESET;
         capture_r <= COUNT_RESET;
         run_r <= 1'b0;
      end else if (go_w) begin
         count_r <= preset_r;
         run_r <= 1'b1;
      end else if (run_r) begin
         case (mode_r)
            MODE_SINGLE, MODE_REPEAT: begin
               if (src_tick) begin
                  count_r <= count_r + 1'b1;
                  if (wrap) begin
                     count_r <= preset_r;
                     run_r <= (mode_r == MODE_REPEAT);
                  end
               end
            end
            MODE_EVT_TIME, MODE_EVT_INTERVAL: begin
               // Trigger 2 captures elapsed time; interval mode also restarts it
               if (t2_rise) begin
                  capture_r <= count_r;
                  if (mode_r == MODE_EVT_INTERVAL) begin
                     count_r <= preset_r;
                  end
               end else if (src_tick) begin
                  count_r <= count_r + 1'b1;
               end
            end
            MODE_FREQ: begin
               // Gate end captures the count; a zero preset means endless gate
               if (ext_r && t1_rise) begin
                  count_r <= count_r + 1'b1;
               end
               if (ext_r && src_tick && preset_r != COUNT_RESET) begin
                  capture_r <= count_r;
                  count_r <= COUNT_RESET;
               end
            end
            default: begin
               run_r <= 1'b0;
            end
         endcase
      end
   end

   // Board outputs registered; strobes one cycle each, trigger 2 level follows its input
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovf_strobe <= 1'b0;
         trig1_strobe <= 1'b0;
         trig2_level <= 1'b0;
      end else begin
         ovf_strobe <= ovf_evt;
         trig1_strobe <= t1_rise;
         trig2_level <= trig2_in;
      end
   end

   // Sticky interrupt status; a new event beats a write-one clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_r <= 2'h0;
      end else begin
         // Clear first; the sets below override it
         for (int i = 0; i < 2; i++) begin
            if (do_write && aw_addr_r == ADDR_IRQ_STAT && w_strb_r[0] && w_data_r[i]) begin
               stat_r[i] <= 1'b0;
            end
         end
         if (ovf_evt) begin
            stat_r[IRQ_OVF] <= 1'b1;
         end
         if (t2_rise) begin
            stat_r[IRQ_TRIG2] <= 1'b1;
         end
      end
   end

   // Registered pin; follows status one cycle late
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat_r & mask_r);
      end
   end

   // Configuration registers written by software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         preset_r <= COUNT_RESET;
         mode_r <= MODE_SINGLE;
         rate_r <= RATE_1MHZ;
         mask_r <= 2'h0;
      end else if (do_write) begin
         if (aw_addr_r == ADDR_CSR && w_strb_r[0]) begin
            // Frequency mode refused without the strap; mode stays as it was
            if (ext_r || mode_t'(w_data_r[CSR_MODE_LO +: 3]) != MODE_FREQ) begin
               mode_r <= mode_t'(w_data_r[CSR_MODE_LO +: 3]);
            end
            rate_r <= w_data_r[CSR_RATE_LO +: 4];
         end else if (aw_addr_r == ADDR_PRESET) begin
            if (w_strb_r[0]) begin
               preset_r[7:0] <= w_data_r[7:0];
            end
            if (w_strb_r[1]) begin
               preset_r[15:8] <= w_data_r[15:8];
            end
         end else if (aw_addr_r == ADDR_IRQ_MASK && w_strb_r[0]) begin
            // Same bit layout as status
            mask_r <= w_data_r[1:0];
         end
      end
   end

   // Write channel capture; address and data may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 4'h0;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         // One-cycle ready, only while that channel holds nothing
         s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[3:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         // Response goes out as the register updates
         if (do_write) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Status view of the command register
   always_comb begin
      csr_view = 32'h00000000;
      csr_view[CSR_MODE_LO +: 3] = mode_r;
      csr_view[CSR_RATE_LO +: 4] = rate_r;
      csr_view[CSR_RUN] = run_r;
      csr_view[CSR_OVF] = stat_r[IRQ_OVF];
      csr_view[CSR_TRIG2] = stat_r[IRQ_TRIG2];
      csr_view[CSR_EXT] = ext_r;
   end

   // Buffer view; endless event counting reads the live count
   always_comb begin
      buf_view = capture_r;
      if (mode_r == MODE_SINGLE || mode_r == MODE_REPEAT) begin
         buf_view = count_r;
      end else if (mode_r == MODE_FREQ && preset_r == COUNT_RESET) begin
         buf_view = count_r;
      end
   end

   // Read channel; buffer reads the live count in single, repeat and endless gate modes, else the capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            // Address decoded at the handshake edge
            if (s_axi_araddr[3:2] == ADDR_CSR[3:2]) begin
               s_axi_rdata <= csr_view;
            end else if (s_axi_araddr[3:2] == ADDR_PRESET[3:2]) begin
               s_axi_rdata <= 32'(buf_view);
            end else if (s_axi_araddr[3:2] == ADDR_IRQ_STAT[3:2]) begin
               s_axi_rdata <= {30'h00000000, stat_r};
            end else begin
               s_axi_rdata <= {30'h00000000, mask_r};
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// file: rtc_host.sv
// Host model: AXI4-Lite master issuing single register reads and writes
`timescale 1ns/100ps
module rtc_host (
   // Clock
   input wire logic aclk,
   // Write channels
   output logic [3:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // Read channels
   output logic [3:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // Idle bus at time zero
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end

   // Address and data go out together; each drops once its own channel takes it
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask

   // Read data is taken at the edge where rvalid is seen
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask
endmodule

// file: rtc_timer_chk.sv
// Checker: port-level properties of the realtime clock
`timescale 1ns/100ps
module rtc_timer_chk
   import rtc_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Board pins
   input wire logic trig1_in,
   input wire logic trig2_in,
   input wire logic ovf_strobe,
   input wire logic trig1_strobe,
   input wire logic trig2_level,
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Trigger pins
   a_trig1_strobe: assert property ($rose(trig1_in) |-> ##[1:2] trig1_strobe)
      else $error("no trig1 strobe after edge");
   a_trig1_single: assert property (trig1_strobe |=> !trig1_strobe)
      else $error("trig1 strobe longer than one cycle");
   a_trig2_copy: assert property ($changed(trig2_in) |=> trig2_level == $past(trig2_in))
      else $error("trig2 level not following input");
   // Overflow strobe is one cycle; no source ticks on adjacent cycles here
   a_ovf_single: assert property (ovf_strobe |=> !ovf_strobe)
      else $error("overflow strobe longer than one cycle");
   // Register bus answers
   a_write_answer: assert property ((s_axi_awvalid && s_axi_awready) |->
      ##[1:4] s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property ((s_axi_arvalid && s_axi_arready) |->
      ##[1:2] s_axi_rvalid)
      else $error("read data late");
   a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   a_resp_okay: assert property ((s_axi_bvalid |-> s_axi_bresp == RESP_OKAY) and
      (s_axi_rvalid |-> s_axi_rresp == RESP_OKAY))
      else $error("response not okay");
   // Main scenarios
   c_ovf: cover property (ovf_strobe);
   c_irq: cover property ($rose(irq));
   c_trig1: cover property (trig1_strobe);
endmodule

// file: programmable_realtime_clock_tb_top.sv
// Testbench: register-driven scenarios for the realtime clock
`timescale 1ns/100ps
module programmable_realtime_clock_tb_top;
   import rtc_pkg::*;
   logic aclk, aresetn, ext_enable, line_clk_evt, trig1_in, trig2_in;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic ovf_strobe, trig1_strobe, trig2_level, irq;
   logic [15:0] p;
   logic [2:0] m;
   int failures, tests_run, seed, ovf_seen, t1_seen, n, k, d;

   // Short prescaler keeps the fast decade rates reachable
   rtc_timer #(.PRE_DIV(2)) u_rtc_timer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .ext_enable, .line_clk_evt, .trig1_in, .trig2_in, .ovf_strobe, .trig1_strobe,
      .trig2_level, .irq);
   // Host side of the register bus
   rtc_host u_rtc_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
      .s_axi_rready);

   // Clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // Strobe counters; registered outputs are stable at the edge
   always @(posedge aclk) begin
      if (ovf_strobe === 1'b1) ovf_seen++;
      if (trig1_strobe === 1'b1) t1_seen++;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int c);
      repeat (c) @(posedge aclk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      u_rtc_host.wr(a, v);
   endtask

   // Read, then step off the edge so outputs have settled
   task automatic rd(input logic [3:0] a);
      u_rtc_host.rd(a, rv);
      #1;
   endtask

   task automatic pulse_line(input int c);
      repeat (c) begin
         @(posedge aclk);
         line_clk_evt <= 1'b1;
         @(posedge aclk);
         line_clk_evt <= 1'b0;
      end
   endtask

   task automatic trig_edge(input int ch);
      @(posedge aclk);
      if (ch == 1) trig1_in <= 1'b1;
      else trig2_in <= 1'b1;
      cyc(3);
      trig1_in <= 1'b0;
      trig2_in <= 1'b0;
      cyc(3);
   endtask

   task automatic start(input logic [15:0] pre, input logic [2:0] md, input logic [3:0] src);
      wr(ADDR_PRESET, {16'h0000, pre});
      wr(ADDR_CSR, {24'h000000, src, md, 1'b1});
      cyc(2);
   endtask

   // Expected mode, source and running fields of the command/status word
   function automatic logic [31:0] csr_fields(logic [2:0] md, logic [3:0] src, logic run);
      return {23'h000000, run, src, md, 1'b0};
   endfunction

   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      seed = 9;
      {aresetn, ext_enable, line_clk_evt, trig1_in, trig2_in} = '0;
      cyc(20);
      aresetn <= 1'b1;
      rd(ADDR_CSR);
      chk(rv & 32'hFFE, 32'h0, "csr reset");
      rd(ADDR_IRQ_STAT);
      chk(rv[1:0], 2'h0, "status reset");
      for (int i = 0; i < 4; i++) begin
         p = 16'($random(seed)) & 16'h7FFF;
         n = 1 + ($random(seed) & 7);
         m = 3'(i & 1);
         start(p, m, SRC_LINE);
         pulse_line(n);
         rd(ADDR_PRESET);
         chk(rv[15:0], p + 16'(n), "line count");
         rd(ADDR_CSR);
         chk(rv & 32'h1FE, csr_fields(m, SRC_LINE, 1'b1), "csr fields");
      end
      // Wrap in repeat mode reloads and interrupts
      wr(ADDR_IRQ_MASK, 32'h1);
      k = ovf_seen;
      start(16'hFFFE, 3'h1, SRC_LINE);
      pulse_line(2);
      rd(ADDR_PRESET);
      chk(rv[15:0], 16'hFFFE, "repeat reload");
      chk(ovf_seen - k, 1, "ovf strobes");
      chk(irq, 1'b1, "irq on ovf");
      wr(ADDR_IRQ_STAT, 32'h1);
      cyc(3);
      #1;
      chk(irq, 1'b0, "irq cleared");
      // Single mode stops at wrap
      start(16'hFFFF, 3'h0, SRC_LINE);
      pulse_line(3);
      rd(ADDR_CSR);
      chk(rv[CSR_RUN], 1'b0, "single stop");
      rd(ADDR_PRESET);
      chk(rv[15:0], 16'hFFFF, "single reload");
      rd(ADDR_IRQ_STAT);
      chk(rv[1:0], 2'h1, "ovf status");
      wr(ADDR_IRQ_STAT, 32'h1);
      // Trigger 2 capture, interrupt and masking
      wr(ADDR_IRQ_MASK, 32'h2);
      n = 1 + ($random(seed) & 7);
      start(p, 3'h2, SRC_LINE);
      pulse_line(n);
      trig_edge(2);
      #1;
      chk(irq, 1'b1, "irq on trig2");
      rd(ADDR_PRESET);
      chk(rv[15:0], p + 16'(n), "event capture");
      rd(ADDR_CSR);
      chk(rv[CSR_TRIG2], 1'b1, "trig2 status");
      wr(ADDR_IRQ_MASK, 32'h0);
      cyc(3);
      #1;
      chk(irq, 1'b0, "masked irq");
      wr(ADDR_IRQ_STAT, 32'h2);
      rd(ADDR_IRQ_STAT);
      chk(rv[1:0], 2'h0, "status cleared");
      start(p, 3'h3, SRC_LINE);
      pulse_line(5);
      trig_edge(2);
      pulse_line(n);
      trig_edge(2);
      rd(ADDR_PRESET);
      chk(rv[15:0], p + 16'(n), "interval capture");
      wr(ADDR_IRQ_STAT, 32'h2);
      // Trigger 1 strobes out
      k = t1_seen;
      n = 1 + ($random(seed) & 3);
      repeat (n) trig_edge(1);
      #1;
      chk(t1_seen - k, n, "trig1 strobes");
      // Strap low refuses frequency mode and slow rates
      start(p, 3'h1, SRC_LINE);
      wr(ADDR_CSR, {24'h000000, SRC_TRIG, 3'h4, 1'b0});
      rd(ADDR_CSR);
      chk(rv[3:1], 3'h1, "freq refused");
      start(p, 3'h0, RATE_10HZ);
      cyc(100);
      rd(ADDR_PRESET);
      chk(rv[15:0], p, "slow rate gated");
      // Strap high: decade rates
      ext_enable <= 1'b1;
      d = 2;
      for (int r = 0; r < 3; r++) begin
         start(16'h0000, 3'h0, 4'(r));
         cyc(20 * d);
         rd(ADDR_PRESET);
         chk(rv[15:0] >= 18 && rv[15:0] <= 25, 1'b1, "rate ticks");
         d = d * 10;
      end
      rd(ADDR_CSR);
      chk(rv[CSR_EXT], 1'b1, "strap bit");
      // Endless gate keeps frequency mode running
      start(16'h0000, 3'h4, SRC_TRIG);
      trig_edge(1);
      trig_edge(1);
      rd(ADDR_CSR);
      chk(rv & 32'h1FE, csr_fields(3'h4, SRC_TRIG, 1'b1), "endless gate");
      rd(ADDR_PRESET);
      chk(rv[15:0], 16'h0002, "event count");
      final_report;
   end

   // Watchdog well beyond the expected run length
   initial begin
      cyc(60000);
      failures++;
      final_report;
   end
endmodule

bind rtc_timer rtc_timer_chk u_rtc_timer_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trig1_in, .trig2_in, .ovf_strobe,
   .trig1_strobe, .trig2_level, .irq);
